// ==== logic/uasc_cfg.svh ====
// Offsets, field positions, codes and reset values of the accessory switch
`ifndef UASC_CFG_SVH
`define UASC_CFG_SVH
`define UASC_I2C_ADDR 7'h25
`define UASC_DEV_ID 8'hA5
`define UASC_REG_ID 8'h01
`define UASC_REG_INT1_MASK 8'h05
`define UASC_REG_INT1 8'h03
`define UASC_REG_ADC 8'h07
`define UASC_REG_DEVT1 8'h0A
`define UASC_INT_OVP 0
`define UASC_INT_OCP 1
`define UASC_INT_ATTACH 2
`define UASC_DEVT_USB_CHG 5
`define UASC_DEVT_DED_CHG 6
`define UASC_ID_FM_OFF_USB 5'h18
`define UASC_ID_FM_BOOT_USB 5'h19
`define UASC_ID_FM_OFF_UART 5'h1C
`define UASC_ID_FM_BOOT_UART 5'h1D
`define UASC_ID_PHONE_POWERED 5'h14
`define UASC_ID_NONE 5'h1F
`define UASC_MASK_RST 3'h0
`define UASC_SYNC_W 12
`define UASC_SYNC_RST 12'hF80
`endif

// ==== logic/uasc_pkg.sv ====
// State type of the accessory switch's serial slave
package uasc_pkg;
   typedef enum logic [2:0] {
      I2C_IDLE = 3'h0,
      I2C_ADDR = 3'h1,
      I2C_ACK_A = 3'h3,
      I2C_WR = 3'h2,
      I2C_ACK_W = 3'h6,
      I2C_RD = 3'h7,
      I2C_ACK_R = 3'h5
   } uasc_i2c_st_t;
endpackage : uasc_pkg

// ==== logic/uasc_regs_if.sv ====
// Register access carrier between the serial slave and the core
`timescale 1ns/1ps
interface uasc_regs_if;
   logic [7:0] ptr;
   logic rd_stb;
   logic wr_stb;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport slave (output ptr, output rd_stb, output wr_stb, output wdata,
      input rdata);
   modport core (input ptr, input rd_stb, input wr_stb, input wdata,
      output rdata);
endinterface : uasc_regs_if

// ==== logic/uasc_i2c_slave.sv ====
// Serial two-wire register slave of the accessory switch
`timescale 1ns/1ps
`include "uasc_cfg.svh"
module uasc_i2c_slave (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Serial pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_o,
   output logic sda_oe,
   // Register side
   uasc_regs_if.slave regs
);
   logic [1:0] scl_m_q, sda_m_q;
   logic scl_q, sda_q, scl_p_q, sda_p_q;
   uasc_pkg::uasc_i2c_st_t st_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, ptr_q, wdata_q;
   logic rw_q, first_q, nack_q, rd_stb_q, wr_stb_q;
   logic start, stop, rise, fall;

   // Pins pass two flops before any edge logic
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         scl_m_q <= 2'h3;
         sda_m_q <= 2'h3;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_m_q <= {scl_m_q[0], scl_in};
         sda_m_q <= {sda_m_q[0], sda_in};
         scl_p_q <= scl_q;
         sda_p_q <= sda_q;
      end
   end
   assign scl_q = scl_m_q[1];
   assign sda_q = sda_m_q[1];
   assign start = scl_q && scl_p_q && sda_p_q && !sda_q;
   assign stop = scl_q && scl_p_q && !sda_p_q && sda_q;
   assign rise = scl_q && !scl_p_q;
   assign fall = !scl_q && scl_p_q;

   // Standard-mode slave with pointer write, auto-increment read
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q <= uasc_pkg::I2C_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         wdata_q <= 8'h00;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         nack_q <= 1'b0;
         rd_stb_q <= 1'b0;
         wr_stb_q <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         rd_stb_q <= 1'b0;
         wr_stb_q <= 1'b0;
         if (start) begin
            st_q <= uasc_pkg::I2C_ADDR;
            cnt_q <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop) begin
            st_q <= uasc_pkg::I2C_IDLE;
            sda_oe <= 1'b0;
         end else if (rise) begin
            if (st_q == uasc_pkg::I2C_ADDR || st_q == uasc_pkg::I2C_WR) begin
               sh_q <= {sh_q[6:0], sda_q};
               cnt_q <= cnt_q + 4'h1;
            end
            if (st_q == uasc_pkg::I2C_ACK_R) nack_q <= sda_q;
         end else if (fall) begin
            case (st_q)
               uasc_pkg::I2C_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     if (sh_q[7:1] == `UASC_I2C_ADDR) begin
                        st_q <= uasc_pkg::I2C_ACK_A;
                        rw_q <= sh_q[0];
                        sda_oe <= 1'b1;
                     end else begin
                        st_q <= uasc_pkg::I2C_IDLE;
                     end
                  end
               end
               uasc_pkg::I2C_ACK_A, uasc_pkg::I2C_ACK_R: begin
                  if (st_q == uasc_pkg::I2C_ACK_R && nack_q) begin
                     st_q <= uasc_pkg::I2C_IDLE;
                     sda_oe <= 1'b0;
                  end else if (rw_q) begin
                     sh_q <= regs.rdata;
                     sda_oe <= !regs.rdata[7];
                     rd_stb_q <= 1'b1;
                     cnt_q <= 4'h1;
                     st_q <= uasc_pkg::I2C_RD;
                  end else begin
                     sda_oe <= 1'b0;
                     cnt_q <= 4'h0;
                     first_q <= 1'b1;
                     st_q <= uasc_pkg::I2C_WR;
                  end
               end
               uasc_pkg::I2C_WR: begin
                  if (cnt_q == 4'h8) begin
                     sda_oe <= 1'b1;
                     st_q <= uasc_pkg::I2C_ACK_W;
                     if (first_q) begin
                        ptr_q <= sh_q;
                     end else begin
                        wdata_q <= sh_q;
                        wr_stb_q <= 1'b1;
                     end
                  end
               end
               uasc_pkg::I2C_ACK_W: begin
                  sda_oe <= 1'b0;
                  cnt_q <= 4'h0;
                  if (!first_q) ptr_q <= ptr_q + 8'h01;
                  first_q <= 1'b0;
                  st_q <= uasc_pkg::I2C_WR;
               end
               uasc_pkg::I2C_RD: begin
                  if (cnt_q == 4'h8) begin
                     sda_oe <= 1'b0;
                     st_q <= uasc_pkg::I2C_ACK_R;
                     // Step ahead now so the next load and its strobe agree
                     ptr_q <= ptr_q + 8'h01;
                  end else begin
                     sda_oe <= !sh_q[6];
                     sh_q <= {sh_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               default: st_q <= uasc_pkg::I2C_IDLE;
            endcase
         end
      end
   end

   // Open drain: only ever drives low
   always_ff @(posedge mclk) begin
      if (sys_rst) sda_o <= 1'b0;
      else sda_o <= 1'b0;
   end

   assign regs.ptr = ptr_q;
   assign regs.rd_stb = rd_stb_q;
   assign regs.wr_stb = wr_stb_q;
   assign regs.wdata = wdata_q;

   a_addr_ack: assert property (
      @(posedge mclk) disable iff (sys_rst)
      fall && st_q == uasc_pkg::I2C_ADDR && cnt_q == 4'h8
      && sh_q[7:1] == `UASC_I2C_ADDR |=> sda_oe)
      else $error("address not acknowledged");
endmodule : uasc_i2c_slave

// ==== logic/uasc_top.sv ====
// Control core of the connector accessory switch
`timescale 1ns/1ps
`include "uasc_cfg.svh"
module uasc_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Analogue detector levels
   input wire logic [4:0] accessory_id_pin,
   input wire logic bus_supply_input,
   input wire logic battery_valid,
   input wire logic bus_over_high,
   input wire logic bus_below_low,
   input wire logic overcurrent_sense,
   input wire logic data_lines_shorted,
   input wire logic charging_port_seen,
   // Factory mode pins
   output logic power_up_o,
   output logic power_up_oe,
   output logic boot_select,
   // Charger detect pin
   output logic charger_detect_out,
   output logic charger_detect_oe,
   // Supply and protection controls
   output logic supply_sel_bus,
   output logic supply_sel_battery,
   output logic bus_pass_en,
   output logic charge_fet_en,
   output logic current_clamp_en,
   // Baseband interface
   output logic int_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_o,
   output logic sda_oe
);
   logic [`UASC_SYNC_W-1:0] sync_m_q, sync_q;
   logic [4:0] id_s, id_prev_q;
   logic bus_v, bat_v, over_hi, below_lo, oc_s, short_s, port_s;
   logic is_factory, boot_hi, phone_powered_device_mode;
   logic ovp_shut_q, oc_prev_q, ded_q, usb_q;
   logic [2:0] int1_q, mask_q, int_set;
   logic int_clr;
   uasc_regs_if regs ();

   // Analogue levels are asynchronous; two flops before use
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         // Id field starts at the no-cable code: no false attach
         sync_m_q <= `UASC_SYNC_RST;
         sync_q <= `UASC_SYNC_RST;
      end else begin
         sync_m_q <= {accessory_id_pin, bus_supply_input, battery_valid,
            bus_over_high, bus_below_low, overcurrent_sense,
            data_lines_shorted, charging_port_seen};
         sync_q <= sync_m_q;
      end
   end
   assign {id_s, bus_v, bat_v, over_hi, below_lo, oc_s, short_s,
      port_s} = sync_q;

   assign is_factory = id_s == `UASC_ID_FM_OFF_USB
      || id_s == `UASC_ID_FM_BOOT_USB || id_s == `UASC_ID_FM_OFF_UART
      || id_s == `UASC_ID_FM_BOOT_UART;
   assign boot_hi = id_s == `UASC_ID_FM_BOOT_USB
      || id_s == `UASC_ID_FM_BOOT_UART;
   assign phone_powered_device_mode = id_s == `UASC_ID_PHONE_POWERED;

   // Factory jig outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         power_up_o <= 1'b0;
         power_up_oe <= 1'b0;
         boot_select <= 1'b0;
      end else begin
         power_up_o <= 1'b0;
         power_up_oe <= is_factory;
         boot_select <= is_factory && boot_hi;
      end
   end

   // Charger type only reported with valid bus present
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ded_q <= 1'b0;
         usb_q <= 1'b0;
         charger_detect_out <= 1'b0;
         charger_detect_oe <= 1'b0;
      end else begin
         ded_q <= bus_v && short_s;
         usb_q <= bus_v && !short_s && port_s;
         charger_detect_out <= 1'b0;
         charger_detect_oe <= ded_q || usb_q;
      end
   end

   // Supply select; bus always wins so a battery start hands over
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         supply_sel_bus <= 1'b0;
         supply_sel_battery <= 1'b0;
      end else begin
         supply_sel_bus <= bus_v;
         supply_sel_battery <= !bus_v && bat_v;
      end
   end

   // Hysteresis between the two thresholds avoids chatter
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ovp_shut_q <= 1'b0;
         bus_pass_en <= 1'b0;
      end else begin
         if (over_hi) ovp_shut_q <= 1'b1;
         else if (below_lo) ovp_shut_q <= 1'b0;
         bus_pass_en <= !over_hi && (below_lo || !ovp_shut_q);
      end
   end

   // Charging switch and current clamp
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         charge_fet_en <= 1'b0;
         current_clamp_en <= 1'b0;
         oc_prev_q <= 1'b0;
      end else begin
         charge_fet_en <= bus_v && !over_hi && !ovp_shut_q;
         current_clamp_en <= oc_s && !phone_powered_device_mode;
         oc_prev_q <= oc_s && !phone_powered_device_mode;
      end
   end

   // Interrupt events; a set in the clearing cycle survives
   assign int_set[`UASC_INT_OVP] = over_hi && !ovp_shut_q;
   assign int_set[`UASC_INT_OCP] = oc_s && !phone_powered_device_mode
      && !oc_prev_q;
   assign int_set[`UASC_INT_ATTACH] = id_s != id_prev_q;
   assign int_clr = regs.rd_stb && regs.ptr == `UASC_REG_INT1;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         int1_q <= 3'h0;
         id_prev_q <= `UASC_ID_NONE;
         int_n <= 1'b1;
      end else begin
         id_prev_q <= id_s;
         int1_q <= (int_clr ? 3'h0 : int1_q) | int_set;
         int_n <= !(|(int1_q & ~mask_q));
      end
   end

   // Baseband writes only reach the mask register
   always_ff @(posedge mclk) begin
      if (sys_rst) mask_q <= `UASC_MASK_RST;
      else if (regs.wr_stb && regs.ptr == `UASC_REG_INT1_MASK)
         mask_q <= regs.wdata[2:0];
   end

   always_comb begin
      case (regs.ptr)
         `UASC_REG_ID: regs.rdata = `UASC_DEV_ID; // Arbitrary value
         `UASC_REG_INT1: regs.rdata = {5'h00, int1_q};
         `UASC_REG_INT1_MASK: regs.rdata = {5'h00, mask_q};
         `UASC_REG_ADC: regs.rdata = {3'h0, id_s};
         `UASC_REG_DEVT1: regs.rdata = {1'b0, ded_q, usb_q, 5'h00};
         default: regs.rdata = 8'h00;
      endcase
   end

   uasc_i2c_slave u_i2c (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_o(sda_o),
      .sda_oe(sda_oe),
      .regs(regs)
   );

   sequence s_ovp_enter;
      over_hi && !ovp_shut_q;
   endsequence
   sequence s_ovp_report;
      ovp_shut_q && int1_q[`UASC_INT_OVP] && !bus_pass_en;
   endsequence

   a_jig_factory: assert property (
      @(posedge mclk) disable iff (sys_rst)
      is_factory |=> power_up_oe && !power_up_o
      && boot_select == $past(boot_hi))
      else $error("factory cable outputs wrong");
   a_jig_release: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !is_factory |=> !power_up_oe && !boot_select)
      else $error("jig not released");
   a_chg_pull: assert property (
      @(posedge mclk) disable iff (sys_rst)
      bus_v && (short_s || port_s) |=> ##1 charger_detect_oe)
      else $error("charger detect not pulled low");
   a_supply_pick: assert property (
      @(posedge mclk) disable iff (sys_rst)
      1'b1 |=> supply_sel_bus == $past(bus_v)
      && supply_sel_battery == ($past(!bus_v) && $past(bat_v)))
      else $error("supply selection wrong");
   a_supply_swap: assert property (
      @(posedge mclk) disable iff (sys_rst)
      supply_sel_battery && bus_v |=> supply_sel_bus && !supply_sel_battery)
      else $error("no handover to bus supply");
   a_ovp_shut: assert property (
      @(posedge mclk) disable iff (sys_rst)
      s_ovp_enter |=> s_ovp_report ##1 (!int_n || mask_q[0]))
      else $error("over-voltage shutdown not reported");
   a_clamp_phone_mode: assert property (
      @(posedge mclk) disable iff (sys_rst)
      phone_powered_device_mode |=> !current_clamp_en)
      else $error("current limited in phone powered mode");
   a_ocp_flag: assert property (
      @(posedge mclk) disable iff (sys_rst)
      oc_s && !phone_powered_device_mode && !oc_prev_q
      |=> current_clamp_en && int1_q[`UASC_INT_OCP])
      else $error("over-current not clamped or flagged");
   a_fet_enable: assert property (
      @(posedge mclk) disable iff (sys_rst)
      bus_v && !over_hi && !ovp_shut_q |=> charge_fet_en)
      else $error("charging switch not enabled");
   a_flag_hold: assert property (
      @(posedge mclk) disable iff (sys_rst)
      int1_q[`UASC_INT_OVP] && !int_clr |=> int1_q[`UASC_INT_OVP])
      else $error("flag lost before read");
   a_flag_clear: assert property (
      @(posedge mclk) disable iff (sys_rst)
      int_clr && !(|int_set) |=> int1_q == 3'h0 ##1 int_n)
      else $error("read did not clear interrupt");
endmodule : uasc_top

// ==== dv/uasc_bbm_model.sv ====
// Baseband two-wire master model that polls and clears the switch
`timescale 1ns/1ps
`include "uasc_cfg.svh"
module uasc_bbm_model (
   // Clock
   input wire logic mclk,
   // Bus lines
   input wire logic sda_line,
   output logic scl_o,
   output logic sda_low
);
   initial begin
      scl_o = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half;
      // Eight cycles, four times the slave's two synchroniser flops
      repeat (8) @(posedge mclk);
   endtask : half
   task automatic start;
      sda_low <= 1'b0;
      half;
      scl_o <= 1'b1;
      half;
      sda_low <= 1'b1;
      half;
      scl_o <= 1'b0;
      half;
   endtask : start
   task automatic stop;
      sda_low <= 1'b1;
      half;
      scl_o <= 1'b1;
      half;
      sda_low <= 1'b0;
      half;
   endtask : stop
   task automatic xfer(input logic [7:0] d, input logic b9,
      output logic [7:0] r, output logic ack);
      logic [8:0] v;
      v = {d, b9};
      for (int i = 8; i >= 0; i--) begin
         sda_low <= ~v[i];
         half;
         scl_o <= 1'b1;
         half;
         v[i] = sda_line;
         scl_o <= 1'b0;
         half;
      end
      r = v[8:1];
      ack = ~v[0];
   endtask : xfer
   task automatic probe(input logic [6:0] a, output logic ack);
      logic [7:0] r;
      start;
      xfer({a, 1'b0}, 1'b1, r, ack);
      stop;
   endtask : probe
   // Ninth bit high on the data byte: master ends the read with a NACK
   task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
      output logic ok);
      logic a0, a1, a2, x;
      start;
      xfer({`UASC_I2C_ADDR, 1'b0}, 1'b1, d, a0);
      xfer(p, 1'b1, d, a1);
      start;
      xfer({`UASC_I2C_ADDR, 1'b1}, 1'b1, d, a2);
      xfer(8'hFF, 1'b1, d, x);
      stop;
      ok = a0 & a1 & a2;
   endtask : read_reg
   task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
      output logic ok);
      logic a0, a1, a2;
      logic [7:0] r;
      start;
      xfer({`UASC_I2C_ADDR, 1'b0}, 1'b1, r, a0);
      xfer(p, 1'b1, r, a1);
      xfer(d, 1'b1, r, a2);
      stop;
      ok = a0 & a1 & a2;
   endtask : write_reg
endmodule : uasc_bbm_model

// ==== dv/uasc_tb_top.sv ====
// Self-checking bench of the accessory switch control core
`timescale 1ns/1ps
module uasc_tb_top;
   // Clock, reset and detector levels
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [4:0] id = 5'h1F;
   logic bus_v = 1'b0;
   logic bat_v = 1'b1;
   logic ovh = 1'b0;
   logic bll = 1'b1;
   logic ocs = 1'b0;
   logic dls = 1'b0;
   logic cps = 1'b0;
   // Observed pins
   logic pu_o, pu_oe, boot, cd_o, cd_oe, s_bus, s_bat, pass, fet, clamp;
   logic int_n, scl, sda_o, sda_oe, sda_low;
   wire sda_line;
   int errors = 0;
   int n_tests = 0;
   logic [7:0] rd;
   logic [2:0] m;
   logic ok;
   logic [4:0] tbl [5] = '{5'h18, 5'h19, 5'h1C, 5'h1D, 5'h1F};
   logic [1:0] sup [4] = '{2'b01, 2'b11, 2'b00, 2'b10};
   always #20 mclk = ~mclk;
   // Pull-up on the data line, either party may pull it low
   assign sda_line = ~((sda_oe & ~sda_o) | sda_low);
   uasc_top uasc_top_inst (.mclk(mclk), .sys_rst(sys_rst),
      .accessory_id_pin(id), .bus_supply_input(bus_v),
      .battery_valid(bat_v), .bus_over_high(ovh), .bus_below_low(bll),
      .overcurrent_sense(ocs), .data_lines_shorted(dls),
      .charging_port_seen(cps), .power_up_o(pu_o), .power_up_oe(pu_oe),
      .boot_select(boot), .charger_detect_out(cd_o),
      .charger_detect_oe(cd_oe), .supply_sel_bus(s_bus),
      .supply_sel_battery(s_bat), .bus_pass_en(pass),
      .charge_fet_en(fet), .current_clamp_en(clamp), .int_n(int_n),
      .scl_in(scl), .sda_in(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
   uasc_bbm_model uasc_bbm_model_inst (.mclk(mclk), .sda_line(sda_line),
      .scl_o(scl), .sda_low(sda_low));
   // {drive low, data, boot} of the factory pins for an id code
   function automatic logic [7:0] exp_jig(input logic [4:0] c);
      logic f;
      f = (c == 5'h18) || (c == 5'h19) || (c == 5'h1C) || (c == 5'h1D);
      return {5'h0, f, 1'b0, f & c[0]};
   endfunction : exp_jig
   function automatic logic [7:0] exp_sup(input logic b, input logic t);
      return {6'h0, b, ~b & t};
   endfunction : exp_sup
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic settle;
      // Covers the sync flops plus the interrupt pin's extra edge
      repeat (6) @(posedge mclk);
      #1;
   endtask : settle
   task automatic rdreg(input logic [7:0] p);
      uasc_bbm_model_inst.read_reg(p, rd, ok);
      check("ack", {7'h0, ok}, 8'h01);
   endtask : rdreg
   task automatic wrreg(input logic [7:0] p, input logic [7:0] d);
      uasc_bbm_model_inst.write_reg(p, d, ok);
      check("ack", {7'h0, ok}, 8'h01);
   endtask : wrreg
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (90000) @(posedge mclk);
      errors++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'h29848bb0));
      repeat (12) @(posedge mclk);
      #1;
      check("rst", {pu_o, pu_oe, boot, cd_oe, s_bus, s_bat, pass, fet},
         8'h00);
      check("rst", {4'h0, sda_o, clamp, int_n, sda_oe}, 8'h02);
      @(posedge mclk);
      sys_rst <= 1'b0;
      settle;
      $display("reset test done");
      for (int i = 0; i < 12; i++) begin
         @(posedge mclk);
         id <= (i < 7) ? 5'($urandom) : tbl[i - 7];
         settle;
         check("jig", {5'h0, pu_oe, pu_o, boot}, exp_jig(id));
      end
      check("int_n", {7'h0, int_n}, 8'h00);
      rdreg(8'h03);
      check("int1", rd & 8'h07, 8'h04);
      settle;
      check("int_n", {7'h0, int_n}, 8'h01);
      $display("factory test done");
      for (int j = 0; j < 4; j++) begin
         @(posedge mclk);
         {bus_v, bat_v} <= sup[j];
         settle;
         check("sup", {6'h0, s_bus, s_bat}, exp_sup(bus_v, bat_v));
         check("fet", {7'h0, fet}, {7'h0, bus_v});
      end
      $display("supply test done");
      @(posedge mclk);
      ovh <= 1'b1;
      bll <= 1'b0;
      settle;
      check("ovp", {5'h0, pass, fet, int_n}, 8'h00);
      rdreg(8'h03);
      check("int1", rd & 8'h01, 8'h01);
      settle;
      check("int_n", {7'h0, int_n}, 8'h01);
      @(posedge mclk);
      ovh <= 1'b0;
      settle;
      check("held", {7'h0, pass}, 8'h00);
      @(posedge mclk);
      bll <= 1'b1;
      settle;
      check("pass", {7'h0, pass}, 8'h01);
      m = 3'($urandom) | 3'h1;
      wrreg(8'h05, {5'h0, m});
      rdreg(8'h05);
      check("mask", rd, {5'h0, m});
      @(posedge mclk);
      ovh <= 1'b1;
      bll <= 1'b0;
      settle;
      check("masked", {7'h0, int_n}, 8'h01);
      rdreg(8'h03);
      check("int1", rd & 8'h01, 8'h01);
      @(posedge mclk);
      ovh <= 1'b0;
      bll <= 1'b1;
      wrreg(8'h05, 8'h00);
      $display("overvoltage test done");
      @(posedge mclk);
      ocs <= 1'b1;
      settle;
      check("ocp", {6'h0, clamp, int_n}, 8'h02);
      rdreg(8'h03);
      check("int1", rd & 8'h02, 8'h02);
      @(posedge mclk);
      ocs <= 1'b0;
      id <= 5'h14;
      settle;
      @(posedge mclk);
      ocs <= 1'b1;
      settle;
      check("ppd", {7'h0, clamp}, 8'h00);
      @(posedge mclk);
      ocs <= 1'b0;
      id <= 5'h1F;
      settle;
      rdreg(8'h03);
      check("int1", rd & 8'h07, 8'h04);
      $display("overcurrent test done");
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk);
         dls <= (k == 0);
         cps <= (k == 1);
         settle;
         check("chg", {6'h0, cd_o, cd_oe}, 8'h01);
         rdreg(8'h0A);
         check("devt", {6'h0, rd[6:5]}, {6'h0, k == 0, k == 1});
      end
      @(posedge mclk);
      bus_v <= 1'b0;
      settle;
      check("nobus", {7'h0, cd_oe}, 8'h00);
      @(posedge mclk);
      cps <= 1'b0;
      $display("charger test done");
      rdreg(8'h01);
      check("id", rd, 8'hA5);
      rdreg(8'h02);
      check("unmap", rd, 8'h00);
      rdreg(8'h07);
      check("adc", rd, {3'h0, id});
      uasc_bbm_model_inst.probe(7'h26, ok);
      check("noack", {7'h0, ok}, 8'h00);
      $display("register test done");
      tally_and_finish;
   end
endmodule : uasc_tb_top
